// ==== verilog/ftc_pkg.sv ====
// shared constants, types and register map of the fixed-point type converter
// Operation
// - Truncate mode drops every input bit below the output LSB with no adjustment.
// - Symmetric rounding goes to the nearest value and takes the larger magnitude on a tie.
// - Convergent rounding goes to the nearest value and takes the even candidate on a tie.
// - Saturate mode clamps an out-of-range value to the largest or smallest output value.
// - Wrap mode keeps only the low-order bits that fit the output width.
// - Flag-as-error overflow behaves in hardware exactly like wrap.
// - With the enable in use and low, the sample counter and all pipeline registers are held.
// - The output is delayed by the configured number of sample periods, at most 9 (10 with max-performance split).
// - Without max-performance pipelining, one core register then a shift register.
// - With max-performance pipelining, latency fills core stages first, excess after.
// - Outputs may be Boolean, signed or unsigned fixed point, single or double float.
// - Fixed-point output is set by a bit count and a binary point, bit zero the LSB.
package ftc_pkg;
    localparam int           IN_W     = 32;
    localparam int           IN_BP    = 16;
    localparam int           WIDE_W   = 64;
    localparam int           OUT_W    = 64;
    localparam int           SR_DEPTH = 8;
    localparam logic [3:0]   SR_D4    = 4'h8;
    localparam logic [3:0]   CORE_MAX = 4'h2;
    localparam logic [5:0]   BP_IN    = 6'h10;
    localparam logic [5:0]   NB_MAX   = 6'h20;
    localparam int           SGL_EW   = 8;
    localparam int           SGL_FW   = 23;
    localparam int           DBL_EW   = 11;
    localparam int           DBL_FW   = 52;

    // register byte offsets within the slave window
    localparam logic [7:0]   OFS_CTRL = 8'h00;
    localparam logic [7:0]   OFS_FMT  = 8'h04;
    localparam logic [7:0]   OFS_PER  = 8'h08;
    localparam logic [7:0]   OFS_STAT = 8'h0c;
    localparam logic [7:0]   OFS_DLO  = 8'h10;
    localparam logic [7:0]   OFS_DHI  = 8'h14;

    typedef enum logic [1:0] {OT_BOOL, OT_FIX, OT_SGL, OT_DBL} ftc_otype_t;
    typedef enum logic [1:0] {QT_TRUNC, QT_SYM, QT_CONV, QT_RSV} ftc_quant_t;
    typedef enum logic [1:0] {OV_SAT, OV_WRAP, OV_FLAG, OV_RSV} ftc_ovf_t;

    // control word, packed exactly as it sits in the low bits of CTRL
    typedef struct packed {
        logic        use_en;
        logic [3:0]  lat;
        logic        maxperf;
        ftc_ovf_t    ovf;
        ftc_quant_t  quant;
        logic        sgn;
        ftc_otype_t  otype;
    } ftc_cfg_t;

    typedef struct packed {
        logic [5:0]  bp;
        logic [1:0]  rsv;
        logic [5:0]  nbits;
    } ftc_fmt_t;

    typedef struct packed {
        logic        en;
        logic        ovf;
    } ftc_stat_t;

    localparam int           CFG_W    = $bits(ftc_cfg_t);
    localparam int           FMT_W    = $bits(ftc_fmt_t);
    localparam int           STAT_W   = $bits(ftc_stat_t);
    localparam logic [12:0]  CTRL_RST = 13'h0105;
    localparam logic [13:0]  FMT_RST  = 14'h0810;
    localparam logic [7:0]   PER_RST  = 8'h00;
endpackage : ftc_pkg

// ==== verilog/ftc_quant.sv ====
// fractional-bit quantizer: scales the input to output LSB units
`timescale 1ns/1ps
module ftc_quant (
    input  wire logic [ftc_pkg::IN_W-1:0]          din_i,
    input  wire logic [5:0]                        bp_i,
    input  wire ftc_pkg::ftc_quant_t               mode_i,
    output logic signed [ftc_pkg::WIDE_W-1:0]      q_o
);
    import ftc_pkg::*;

    logic signed [WIDE_W-1:0] wide;
    logic        [5:0]        sdn;
    logic        [5:0]        sup;
    logic        [5:0]        sm1;
    logic signed [WIDE_W-1:0] trunc;
    logic        [WIDE_W-1:0] below;
    logic                     down;
    logic                     half;
    logic                     rest;
    logic                     add;

    // floor shift is the truncation; the dropped bits decide the rounding carry
    assign wide  = {{(WIDE_W-IN_W){din_i[IN_W-1]}}, din_i};
    assign down  = bp_i < BP_IN;
    assign sdn   = BP_IN - bp_i;
    assign sup   = bp_i - BP_IN;
    assign sm1   = sdn - 6'h01;
    assign trunc = wide >>> sdn;
    assign below = (64'h1 << sm1) - 64'h1;
    assign half  = wide[sm1];
    assign rest  = |(wide & below);
    // a tie on a negative value must not carry, that would move toward zero
    assign add   = (mode_i == QT_SYM)  ? (half & (rest | ~wide[WIDE_W-1])) :
                   (mode_i == QT_CONV) ? (half & (rest | trunc[0])) : 1'b0;
    assign q_o   = down ? trunc + 64'(add) : wide <<< sup;
endmodule : ftc_quant

// ==== verilog/ftc_float.sv ====
// fixed-point to floating-point encoder; mantissa bits beyond the field are dropped
`timescale 1ns/1ps
module ftc_float #(
    parameter int EW = 8,
    parameter int FW = 23
) (
    input  wire logic [ftc_pkg::IN_W-1:0] din_i,
    output logic      [EW+FW:0]           f_o
);
    import ftc_pkg::*;

    localparam int BIAS = (1 << (EW-1)) - 1;

    logic [IN_W-1:0]   mag;
    logic [4:0]        msb;
    logic [2*IN_W-1:0] norm;
    logic [EW-1:0]     expo;

    // the most negative input still fits: its magnitude is read unsigned
    assign mag = din_i[IN_W-1] ? (~din_i + 32'h1) : din_i;

    // leading-one search, highest set bit wins
    always_comb begin
        msb = 5'h00;
        for (int i = 0; i < IN_W; i++) begin
            if (mag[i]) begin
                msb = 5'(i);
            end
        end
    end

    assign norm = {mag, 32'h0} << (5'h1f - msb);
    assign expo = EW'(BIAS - IN_BP) + EW'(msb);
    assign f_o  = (mag == 32'h0) ? '0 : {din_i[IN_W-1], expo, norm[2*IN_W-2 -: FW]};
endmodule : ftc_float

// ==== verilog/ftc_top.sv ====
// converter top: AHB-Lite register slave, conversion core and latency pipeline
`timescale 1ns/1ps
module ftc_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        hsel_i,
    input  wire logic [31:0]                 haddr_i,
    input  wire logic [1:0]                  htrans_i,
    input  wire logic                        hwrite_i,
    input  wire logic [2:0]                  hsize_i,
    input  wire logic [31:0]                 hwdata_i,
    input  wire logic                        hready_i,
    output logic      [31:0]                 hrdata_o,
    output logic                             hreadyout_o,
    output logic                             hresp_o,
    input  wire logic [ftc_pkg::IN_W-1:0]    din_i,
    input  wire logic                        en_i,
    output logic      [ftc_pkg::OUT_W-1:0]   dout_o
);
    import ftc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register slave

    ftc_cfg_t   cfg;
    ftc_fmt_t   fmt;
    logic [7:0] per;
    logic [7:0] a_addr;
    logic       a_we;
    logic       ap;
    logic       wr_ctrl;
    logic       wr_fmt;
    logic       wr_per;
    logic       wr_any;
    ftc_stat_t  stat;

    // single-word transfers only; hsize is accepted but not checked
    assign ap      = hsel_i & htrans_i[1] & hready_i;
    assign wr_ctrl = a_we & (a_addr == OFS_CTRL);
    assign wr_fmt  = a_we & (a_addr == OFS_FMT);
    assign wr_per  = a_we & (a_addr == OFS_PER);
    assign wr_any  = wr_ctrl | wr_fmt | wr_per;

    // address phase capture; zero wait states so the bus never stalls
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            a_addr <= 8'h00;
            a_we   <= 1'b0;
        end else begin
            a_addr <= haddr_i[7:0];
            a_we   <= ap & hwrite_i;
        end
    end

    // data phase writes
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg <= ftc_cfg_t'(CTRL_RST);
            fmt <= ftc_fmt_t'(FMT_RST);
            per <= PER_RST;
        end else begin
            if (wr_ctrl) cfg <= ftc_cfg_t'(hwdata_i[CFG_W-1:0]);
            if (wr_fmt)  fmt <= ftc_fmt_t'(hwdata_i[FMT_W-1:0]);
            if (wr_per)  per <= hwdata_i[7:0];
        end
    end

    // read mux of the config flops, live status and dout; unmapped offsets read zero with an OKAY response
    assign hrdata_o    = (a_addr == OFS_CTRL) ? 32'(cfg) :
                         (a_addr == OFS_FMT)  ? 32'(fmt) :
                         (a_addr == OFS_PER)  ? 32'(per) :
                         (a_addr == OFS_STAT) ? 32'(stat) :
                         (a_addr == OFS_DLO)  ? dout_o[31:0] :
                         (a_addr == OFS_DHI)  ? dout_o[63:32] : 32'h0;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // sample timing

    logic [7:0] cnt;
    logic       en_eff;
    logic       tick;
    logic       adv;

    // a sample period spans per+1 clocks when the datapath is over-clocked
    assign en_eff = ~cfg.use_en | en_i;
    // a period shortened in mid-count must not wait for the counter to wrap
    assign tick   = (cnt >= per);
    assign adv    = tick & en_eff;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt <= 8'h00;
        end else if (en_eff) begin
            cnt <= tick ? 8'h00 : cnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // conversion core

    logic signed [WIDE_W-1:0] q_comb;
    logic signed [WIDE_W-1:0] q_reg;
    logic signed [WIDE_W-1:0] mid;
    logic        [IN_W-1:0]   din_reg;
    logic        [IN_W-1:0]   din_sel;
    logic        [5:0]        nb;
    logic        [WIDE_W-1:0] mask;
    logic signed [WIDE_W-1:0] maxv;
    logic signed [WIDE_W-1:0] minv;
    logic                     over;
    logic                     under;
    logic        [WIDE_W-1:0] fix_val;
    logic        [31:0]       f_sgl;
    logic        [63:0]       f_dbl;
    logic        [OUT_W-1:0]  core_val;
    logic                     core_ov;
    logic                     split;

    ftc_quant u_quant (
        .din_i  (din_i),
        .bp_i   (fmt.bp),
        .mode_i (cfg.quant),
        .q_o    (q_comb)
    );

    // the optional mid-core register only exists in max-performance mode
    assign split   = cfg.maxperf & (cfg.lat >= CORE_MAX);
    assign mid     = split ? q_reg : q_comb;
    assign din_sel = split ? din_reg : din_i;

    // range of the output format; nbits out of 1..32 is clamped
    assign nb      = (fmt.nbits == 6'h00) ? 6'h01 :
                     (fmt.nbits > NB_MAX) ? NB_MAX : fmt.nbits;
    assign mask    = (64'h1 << nb) - 64'h1;
    assign maxv    = cfg.sgn ? $signed(mask >> 1) : $signed(mask);
    assign minv    = cfg.sgn ? $signed(~(mask >> 1)) : 64'sh0;
    assign over    = mid > maxv;
    assign under   = mid < minv;
    // flag mode is a simulation notion only, so it shares the wrap path
    assign fix_val = ((cfg.ovf == OV_SAT) ? (over  ? maxv :
                                             under ? minv : mid)
                                          : mid) & mask;

    ftc_float #(.EW(SGL_EW), .FW(SGL_FW)) u_sgl (
        .din_i (din_sel),
        .f_o   (f_sgl)
    );

    ftc_float #(.EW(DBL_EW), .FW(DBL_FW)) u_dbl (
        .din_i (din_sel),
        .f_o   (f_dbl)
    );

    // output type select
    assign core_val = (cfg.otype == OT_BOOL) ? 64'(|din_sel) :
                      (cfg.otype == OT_FIX)  ? fix_val :
                      (cfg.otype == OT_SGL)  ? 64'(f_sgl) : f_dbl;
    assign core_ov  = (cfg.otype == OT_FIX) & (over | under);

    ////////////////////////////////////////////////////////////////////////////
    // latency pipeline

    logic [OUT_W-1:0] core_reg;
    logic [OUT_W-1:0] sr [SR_DEPTH];
    logic [3:0]       core_stages;
    logic [3:0]       ext_raw;
    logic [3:0]       extra;
    logic             ov_last;

    // latency goes to the core first, the rest to the output shift register
    assign core_stages = (cfg.lat == 4'h0) ? 4'h0 : (split ? CORE_MAX : 4'h1);
    assign ext_raw     = cfg.lat - core_stages;
    assign extra       = (ext_raw > SR_D4) ? SR_D4 : ext_raw;  // deeper requests are capped

    // core registers; reset clears them regardless of the enable
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_reg    <= '0;
            din_reg  <= '0;
            core_reg <= '0;
            ov_last  <= 1'b0;
        end else if (adv) begin
            q_reg    <= q_comb;
            din_reg  <= din_i;
            core_reg <= core_val;
            ov_last  <= core_ov;
        end
    end

    // output shift register, one sample per stage; the head stage reads the core
    for (genvar i = 0; i < SR_DEPTH; i++) begin : g_sr
        logic [OUT_W-1:0] src;
        if (i == 0) begin : g_head
            assign src = core_reg;
        end else begin : g_tail
            assign src = sr[i-1];
        end
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                sr[i] <= '0;
            end else if (adv) begin
                sr[i] <= src;
            end
        end
    end

    assign dout_o = (extra != 4'h0)    ? sr[3'(extra - 4'h1)] :
                    (cfg.lat == 4'h0)  ? core_val : core_reg;
    assign stat   = '{en: en_eff, ovf: ov_last};

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic signed [WIDE_W-1:0] wide;
    logic signed [WIDE_W-1:0] lsb;
    logic signed [WIDE_W-1:0] err;
    logic signed [WIDE_W-1:0] err2;
    logic                     down;
    logic                     tie;

    assign wide = {{(WIDE_W-IN_W){din_i[IN_W-1]}}, din_i};
    assign down = fmt.bp < BP_IN;
    assign lsb  = 64'sh1 <<< (BP_IN - fmt.bp);
    assign err  = (q_comb <<< (BP_IN - fmt.bp)) - wide;
    assign err2 = err <<< 1;
    assign tie  = (err2 == lsb) || (err2 == -lsb);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    property p_trunc;
        cfg.quant == QT_TRUNC && down |-> err <= 0 && err > -lsb;
    endproperty
    a_trunc: assert property (p_trunc) else $error("truncation adjusted value");

    property p_sym;
        cfg.quant == QT_SYM && down |->
            err2 <= lsb && err2 >= -lsb && (!tie || (wide < 0 ? err < 0 : err > 0));
    endproperty
    a_sym: assert property (p_sym) else $error("symmetric rounding wrong");

    property p_conv;
        cfg.quant == QT_CONV && down |->
            err2 <= lsb && err2 >= -lsb && (!tie || !q_comb[0]);
    endproperty
    a_conv: assert property (p_conv) else $error("convergent rounding wrong");

    property p_sat;
        cfg.otype == OT_FIX && cfg.ovf == OV_SAT && over |-> core_val == (maxv & mask);
    endproperty
    a_sat: assert property (p_sat) else $error("saturation value wrong");

    property p_wrap;
        cfg.otype == OT_FIX && cfg.ovf != OV_SAT |-> ((core_val ^ mid) & mask) == 0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap lost low bits");

    property p_width;
        cfg.otype == OT_FIX |-> (core_val & ~mask) == 0;
    endproperty
    a_width: assert property (p_width) else $error("bits above output width");

    property p_hold;
        !adv |=> $stable(core_reg) && $stable(q_reg) && $stable(sr[SR_DEPTH-1]);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while held");

    property p_lat1;
        adv && cfg.lat == 4'h1 && !wr_any |=> dout_o == $past(core_val);
    endproperty
    a_lat1: assert property (p_lat1) else $error("latency one misplaced");

    property p_plain;
        !cfg.maxperf && cfg.lat != 4'h0 |-> core_stages == 4'h1 && !split;
    endproperty
    a_plain: assert property (p_plain) else $error("plain core stage count");

    property p_maxp;
        cfg.maxperf && cfg.lat >= 4'h2 && cfg.lat <= 4'ha |->
            core_stages == 4'h2 && extra == cfg.lat - 4'h2;
    endproperty
    a_maxp: assert property (p_maxp) else $error("pipeline split wrong");

    property p_types;
        (cfg.otype == OT_BOOL |-> core_val[63:1] == 0) and
        (cfg.otype == OT_SGL |-> core_val[63:32] == 0 && core_val[31] == din_sel[31]);
    endproperty
    a_types: assert property (p_types) else $error("output type layout wrong");

    property p_rst;
        $rose(rst_b_i) |-> core_reg == 0 && q_reg == 0 && sr[0] == 0 && cnt == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("pipeline not cleared");

    c_sym_tie: cover property (cfg.quant == QT_SYM && down && tie);
    c_sat:     cover property (cfg.ovf == OV_SAT && over && adv);
    c_maxp:    cover property (split && extra != 4'h0 && adv);
endmodule : ftc_top

// ==== tb/ftc_partner.sv ====
// upstream sample source with a history of the samples the converter accepted
`timescale 1ns/1ps
module ftc_partner (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        step_i,
    input  wire logic [31:0] nxt_i,
    output logic      [31:0] din_o
);
    logic [31:0] hist [1:15];

    ////////////////////////////////////////////////////////////////////////////
    // upstream holds its sample between advances, like a real source would;
    // hist[k] is the sample taken k advances ago, so the bench can predict dout
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            din_o <= 32'h0;
            for (int k = 1; k < 16; k++) begin
                hist[k] <= 32'h0;
            end
        end else if (step_i) begin
            din_o   <= nxt_i;
            hist[1] <= din_o;
            for (int k = 2; k < 16; k++) begin
                hist[k] <= hist[k-1];
            end
        end
    end
endmodule : ftc_partner

// ==== tb/fixed_point_type_converter_tb_top.sv ====
// self-checking bench: register access, corner and random conversion streams
`timescale 1ns/1ps
module fixed_point_type_converter_tb_top;
    import ftc_pkg::*;
    logic        clk_i   = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic        en      = 1'b1;
    logic [1:0]  htrans  = 2'h0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] nxt     = 32'h0;
    logic [12:0] ctrl    = 13'h0105;
    logic [13:0] fmt     = 14'h0810;
    logic [31:0] din, hrdata, r;
    logic [63:0] dout, prev;
    logic        hready, hresp, step;
    int          mismatches = 0;
    int          n_compared = 0;
    // ties, rounding carries and extremes for a 4-bit output with 2 fraction bits
    logic [31:0] corner [0:7] = '{32'h00016000, 32'h0001a000, 32'h0001e000, 32'hfffea000,
                                  32'hfffe6000, 32'h00012000, 32'h00000000, 32'h80000000};

    always #5 clk_i = ~clk_i;
    assign step = !ctrl[12] | en;

    ftc_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .din_i(din), .en_i(en), .dout_o(dout));
    ftc_partner i_part (.clk_i(clk_i), .rst_b_i(rst_b_i), .step_i(step), .nxt_i(nxt),
        .din_o(din));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
            mismatches++;
        end
    endtask : chk

    // the bus wait is bounded: a slave that never answers ends the run
    task automatic wt;
        int n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            $display("ERROR %0t bus wait timed out", $time);
            mismatches++;
            end_sim();
        end
    endtask : wt

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk_i);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wt();
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
        rd = hrdata;
    endtask : ahb

    task automatic cfg(input logic [12:0] c, input logic [13:0] f);
        ahb(1'b1, OFS_CTRL, {19'h0, c}, r);
        ahb(1'b1, OFS_FMT, {18'h0, f}, r);
        ctrl = c;
        fmt  = f;
    endtask : cfg

    ////////////////////////////////////////////////////////////////////////////
    // float reference: mantissa truncated toward zero, like the encoder
    function automatic logic [63:0] flt(logic [31:0] d, int ew, int fw);
        logic [63:0] m;
        int          p;
        m = d[31] ? {32'h0, -d} : {32'h0, d};
        if (m == 64'h0) return 64'h0;
        p = 63;
        while (!m[p]) p--;
        m = m << (64 - p);
        return (m >> (64 - fw)) | (64'(p - 16 + (1 << (ew - 1)) - 1) << fw)
               | (64'(d[31]) << (ew + fw));
    endfunction : flt

    // rounding first, then range handling on the rounded value
    function automatic logic [63:0] conv(logic [31:0] d, logic [12:0] c, logic [13:0] f);
        longint v, q, rem, half, hi, lo;
        int     nb, sh;
        if (c[1:0] == 2'h0) return {63'h0, d != 32'h0};
        if (c[1:0] == 2'h2) return flt(d, 8, 23);
        if (c[1:0] == 2'h3) return flt(d, 11, 52);
        v  = longint'(signed'(d));
        nb = (f[5:0] == 6'h0) ? 1 : (f[5:0] > 6'h20) ? 32 : int'(f[5:0]);
        sh = 16 - int'(f[13:8]);
        q  = (sh <= 0) ? (v <<< -sh) : (v >>> sh);
        if (sh > 0 && (c[4:3] == 2'h1 || c[4:3] == 2'h2)) begin
            rem  = v - (q <<< sh);
            half = 64'sh1 <<< (sh - 1);
            if (rem > half || (rem == half && ((c[4:3] == 2'h1) ? q >= 0 : q[0]))) q++;
        end
        hi = c[2] ? (64'sh1 <<< (nb - 1)) - 1 : (64'sh1 <<< nb) - 1;
        lo = c[2] ? -(64'sh1 <<< (nb - 1)) : 64'sh0;
        if (c[6:5] == 2'h0) q = (q > hi) ? hi : (q < lo) ? lo : q;
        return q & ((64'sh1 <<< nb) - 1);
    endfunction : conv

    // twelve flushing samples with enable high, then checked samples
    task automatic stream(input int cyc);
        int lat;
        lat = int'(ctrl[11:8]);
        for (int i = 0; i < cyc + 12; i++) begin
            @(posedge clk_i);
            nxt <= (i >= 12 && i < 20) ? corner[i-12] : $urandom;
            en  <= (!ctrl[12] || i < 12) ? 1'b1 : 1'($urandom);
            #1;
            if (i >= 12) begin
                chk(dout, conv(lat == 0 ? din : i_part.hist[lat], ctrl, fmt), "sample");
            end
        end
    endtask : stream

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(27));
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // reset values, unmapped place, read-back
        ahb(1'b0, OFS_CTRL, 32'h0, r);
        chk({32'h0, r}, {51'h0, CTRL_RST}, "ctrl reset");
        ahb(1'b0, OFS_FMT, 32'h0, r);
        chk({32'h0, r}, {50'h0, FMT_RST}, "fmt reset");
        ahb(1'b0, OFS_PER, 32'h0, r);
        chk({32'h0, r}, {56'h0, PER_RST}, "per reset");
        ahb(1'b1, 8'h20, 32'hffffffff, r);
        ahb(1'b0, 8'h20, 32'h0, r);
        chk({32'h0, r}, 64'h0, "unmapped read");
        prev = {32'h0, $urandom & 32'h3fff};
        ahb(1'b1, OFS_FMT, prev[31:0], r);
        ahb(1'b0, OFS_FMT, 32'h0, r);
        chk({32'h0, r}, prev, "fmt read-back");
        chk({63'h0, hresp}, 64'h0, "response okay");
        $display("test registers done");
        // every rounding and overflow code on the 4.2 tie and carry cases
        for (int q = 0; q < 4; q++) begin
            for (int o = 0; o < 4; o++) begin
                cfg({1'b0, 4'h2, 1'(q), 2'(o), 2'(q), 1'(o), 2'h1}, 14'h0204);
                stream(10);
            end
        end
        cfg(13'h1927, 14'h1020);
        stream(20);
        cfg(13'h1ab1, 14'h0808);
        stream(20);
        // single float behind two stages, then Boolean with no latency
        cfg(13'h0202, 14'h1020);
        stream(10);
        cfg(13'h0000, 14'h0810);
        stream(10);
        $display("test corners done");
        for (int k = 0; k < 24; k++) begin
            cfg({1'($urandom), 4'($urandom % 9), 1'($urandom), 2'($urandom), 2'($urandom),
                 1'($urandom), 2'($urandom)}, {6'($urandom % 25), 2'($urandom),
                 6'($urandom % 40)});
            stream(30);
        end
        $display("test random done");
        // three clocks a sample: dout moves only on every third edge
        cfg(13'h0105, 14'h1020);
        ahb(1'b1, OFS_PER, 32'h2, r);
        // let the edge that ended the write settle before taking the reference
        #1;
        prev = dout;
        for (int i = 0; i < 10 && dout === prev; i++) begin
            @(posedge clk_i);
            nxt <= $urandom;
            #1;
        end
        for (int i = 1; i < 13; i++) begin
            prev = dout;
            @(posedge clk_i);
            nxt <= $urandom;
            #1;
            chk({63'h0, dout !== prev}, {63'h0, i % 3 == 0}, "sample period");
        end
        ahb(1'b1, OFS_PER, 32'h0, r);
        $display("test period done");
        // reset while the enable holds everything
        cfg(13'h1305, 14'h1020);
        stream(8);
        @(posedge clk_i);
        en <= 1'b0;
        // pipeline held: the output words and status read back what is stored
        ahb(1'b0, OFS_DLO, 32'h0, r);
        prev = conv(i_part.hist[3], ctrl, fmt);
        chk({32'h0, r}, {32'h0, prev[31:0]}, "dout low held");
        ahb(1'b0, OFS_DHI, 32'h0, r);
        chk({32'h0, r}, {32'h0, prev[63:32]}, "dout high held");
        ahb(1'b0, OFS_STAT, 32'h0, r);
        chk({32'h0, r}, 64'h0, "status held");
        @(posedge clk_i);
        en      <= 1'b0;
        rst_b_i <= 1'b0;
        #1;
        chk(dout, 64'h0, "dout in reset");
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        ctrl = CTRL_RST;
        fmt  = FMT_RST;
        ahb(1'b0, OFS_CTRL, 32'h0, r);
        chk({32'h0, r}, {51'h0, CTRL_RST}, "ctrl after reset");
        stream(10);
        $display("test reset done");
        end_sim();
    end
endmodule : fixed_point_type_converter_tb_top
